// ---- hdl/pmx_params.svh ----
// constants for the port pin function multiplexer
// Functional notes
// (RQ1) port zero: GPIO plus multiplexed address/data
// (RQ2) port one: written one drives strong two clocks
// (RQ3) port one bit zero: timer C event/clock-out
// (RQ4) port one bit one: timer C control input
// (RQ5) port two: GPIO plus high address byte
// (RQ6) port three: quasi drive, alternate pin roles
// (RQ7) port three bits zero/one: serial receive, transmit
// (RQ8) port three bits two/three: interrupts A/B, low
// (RQ9) port three bits four/five: timer A/B events
// (RQ10) port three bits six/seven: write/read strobes
// (RQ11) port four: extra quasi GPIO, large packages
// (RQ12) port four bits two/three: interrupts D/C, low
// (RQ13) reset pin high two machine cycles resets
// (RQ14) low fetch select means external code; pull-up
// (RQ15) address latch pulse on each external access
// (RQ16) program read strobe low on external fetch
// (RQ17) alternate output passes only when latch one
`ifndef PMX_PARAMS_SVH
`define PMX_PARAMS_SVH
`define PMX_NPINS 36
`define PMX_P0 0
`define PMX_P1 8
`define PMX_P2 16
`define PMX_P3 24
`define PMX_P4 32
`define PMX_B_RXD 0
`define PMX_B_TXD 1
`define PMX_B_IRQA 2
`define PMX_B_IRQB 3
`define PMX_B_TMRA 4
`define PMX_B_TMRB 5
`define PMX_B_WR 6
`define PMX_B_RD 7
`define PMX_B_TMRC 0
`define PMX_B_TMRCX 1
`define PMX_B_IRQD 2
`define PMX_B_IRQC 3
`define PMX_STRONG_CLKS 2'h2
`define PMX_MC_CLKS 12
`define PMX_RST_MC 2
`define PMX_RST_CLKS (`PMX_MC_CLKS * `PMX_RST_MC)
`define PMX_RST_LAST 5'(`PMX_RST_CLKS - 1)
`define PMX_PIN_RST 36'hF_FFFF_FFFF
`endif

// ---- hdl/pmx_pkg.sv ----
// types shared by the port pin function multiplexer
package pmx_pkg;
    // external memory request from the core
    typedef struct packed {
        logic access;
        logic aleReq;
        logic fetch;
        logic wrReq;
        logic rdReq;
        logic dataDrive;
        logic [15:0] addr;
        logic [7:0] dataOut;
    } pmx_bus_req_type;
    // alternate outputs from peripherals
    typedef struct packed {
        logic txd;
        logic timerCClk;
        logic timerCClkEn;
    } pmx_alt_out_type;
    // alternate inputs toward peripherals
    typedef struct packed {
        logic rxd;
        logic extIrqAN;
        logic extIrqBN;
        logic extIrqCN;
        logic extIrqDN;
        logic timerAEventIn;
        logic timerBEventIn;
        logic timerCEventClkout;
        logic timerCExtControl;
    } pmx_alt_in_type;
    // reset pin qualifier states
    typedef enum logic [1:0] {
        RST_IDLE = 2'b00,
        RST_COUNT = 2'b01,
        RST_ACTIVE = 2'b10
    } pmx_rst_state_type;
endpackage

// ---- hdl/pmx_port_mux.sv ----
// port pin function multiplexer: five ports, bus pins, reset pin
`timescale 1ns/1ps
`default_nettype none
`include "pmx_params.svh"
module pmx_port_mux (
    input wire logic clk, // core clock
    input wire logic resetn, // sync reset, low
    input wire logic [35:0] portLatch, // port latches from core
    input wire pmx_pkg::pmx_bus_req_type busReq, // memory request
    input wire pmx_pkg::pmx_alt_out_type altOut, // peripheral outputs
    input wire logic [35:0] pinIn, // pin levels
    output logic [35:0] pinOut, // pin drive value
    output logic [35:0] pinOe, // pin strong drive enable
    output logic [35:0] portRead, // sampled pins to core
    output pmx_pkg::pmx_alt_in_type altIn, // peripheral inputs
    input wire logic resetPin, // reset pin, high
    output logic coreResetReq, // full reset to core
    input wire logic externalFetchSelectN, // fetch select pin
    output logic externalFetchPullUp, // weak pull on select
    output logic externalFetch, // external code selected
    output logic addrLatchPulse, // address latch pin
    output logic programReadStrobeN // program read pin
);
    import pmx_pkg::*;

    logic [35:0] v;
    logic [35:0] frc;
    logic [35:0] flt;
    logic [35:0] pinOut_q;
    logic [35:0] pinOe_q;
    logic [35:0] pinOe_d;
    logic [1:0] cnt_q [36];
    logic [1:0] cnt_d [36];
    logic [35:0] portRead_q;
    pmx_alt_in_type altIn_q;
    pmx_alt_in_type altIn_d;
    logic ale_q;
    logic ale_d;
    logic psenN_q;
    logic psenN_d;
    logic extFetch_q;
    pmx_rst_state_type rstState_q;
    pmx_rst_state_type rstState_d;
    logic [4:0] rstCnt_q;
    logic [4:0] rstCnt_d;
    logic coreReset_q;

    // --------------------------------------------------------------
    // pin value selection
    // --------------------------------------------------------------
    // desired level, bus force and float per pin
    always_comb
    begin
        v = portLatch;
        frc = '0;
        flt = '0;
        // (RQ5) high address byte
        if (busReq.access)
        begin
            v[`PMX_P2 +: 8] = busReq.addr[15:8];
            frc[`PMX_P2 +: 8] = 8'hFF;
            // (RQ1) low address then data
            if (busReq.aleReq)
            begin
                v[`PMX_P0 +: 8] = busReq.addr[7:0];
                frc[`PMX_P0 +: 8] = 8'hFF;
            end
            else if (busReq.dataDrive)
            begin
                v[`PMX_P0 +: 8] = busReq.dataOut;
                frc[`PMX_P0 +: 8] = 8'hFF;
            end
            else
            begin
                v[`PMX_P0 +: 8] = 8'hFF;
                flt[`PMX_P0 +: 8] = 8'hFF;
            end
        end
        // (RQ3) timer C clock-out, (RQ17) gated by latch
        v[`PMX_P1 + `PMX_B_TMRC] = portLatch[`PMX_P1 + `PMX_B_TMRC]
            & (altOut.timerCClkEn ? altOut.timerCClk : 1'b1);
        // (RQ7) serial transmit, (RQ17) gated by latch
        v[`PMX_P3 + `PMX_B_TXD] = portLatch[`PMX_P3 + `PMX_B_TXD] & altOut.txd;
        // (RQ10) data write and read strobes
        v[`PMX_P3 + `PMX_B_WR] = portLatch[`PMX_P3 + `PMX_B_WR]
            & ~(busReq.access & busReq.wrReq);
        v[`PMX_P3 + `PMX_B_RD] = portLatch[`PMX_P3 + `PMX_B_RD]
            & ~(busReq.access & busReq.rdReq);
    end

    // --------------------------------------------------------------
    // quasi-bidirectional drivers
    // --------------------------------------------------------------
    // (RQ2) strong high for two clocks after a rise
    always_comb
    begin
        for (int i = 0; i < `PMX_NPINS; i++)
        begin
            if (v[i] & ~pinOut_q[i] & ~flt[i])
                cnt_d[i] = `PMX_STRONG_CLKS;
            else if (cnt_q[i] != 2'h0)
                cnt_d[i] = cnt_q[i] - 2'h1;
            else
                cnt_d[i] = 2'h0;
            // (RQ6) (RQ11) same drive on ports three, four
            pinOe_d[i] = frc[i] | (~flt[i] & (~v[i] | (cnt_d[i] != 2'h0)));
        end
    end

    // pin registers
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pinOut_q <= `PMX_PIN_RST;
            pinOe_q <= '0;
            portRead_q <= `PMX_PIN_RST;
            for (int i = 0; i < `PMX_NPINS; i++)
                cnt_q[i] <= 2'h0;
        end
        else
        begin
            pinOut_q <= v;
            pinOe_q <= pinOe_d;
            portRead_q <= pinIn;
            for (int i = 0; i < `PMX_NPINS; i++)
                cnt_q[i] <= cnt_d[i];
        end
    end

    assign pinOut = pinOut_q;
    assign pinOe = pinOe_q;
    assign portRead = portRead_q;

    // --------------------------------------------------------------
    // alternate inputs and bus strobes
    // --------------------------------------------------------------
    // next values of peripheral inputs and strobes
    always_comb
    begin
        // (RQ7) serial receive
        altIn_d.rxd = pinIn[`PMX_P3 + `PMX_B_RXD];
        // (RQ8) interrupts A and B
        altIn_d.extIrqAN = pinIn[`PMX_P3 + `PMX_B_IRQA];
        altIn_d.extIrqBN = pinIn[`PMX_P3 + `PMX_B_IRQB];
        // (RQ12) interrupts D and C
        altIn_d.extIrqDN = pinIn[`PMX_P4 + `PMX_B_IRQD];
        altIn_d.extIrqCN = pinIn[`PMX_P4 + `PMX_B_IRQC];
        // (RQ9) timer A and B events
        altIn_d.timerAEventIn = pinIn[`PMX_P3 + `PMX_B_TMRA];
        altIn_d.timerBEventIn = pinIn[`PMX_P3 + `PMX_B_TMRB];
        // (RQ3) (RQ4) timer C event and control
        altIn_d.timerCEventClkout = pinIn[`PMX_P1 + `PMX_B_TMRC];
        altIn_d.timerCExtControl = pinIn[`PMX_P1 + `PMX_B_TMRCX];
        // (RQ15) address latch pulse
        ale_d = busReq.access & busReq.aleReq;
        // (RQ16) program read strobe
        psenN_d = ~(busReq.access & busReq.fetch);
    end

    // strobe and input registers
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            altIn_q <= '1;
            ale_q <= 1'b0;
            psenN_q <= 1'b1;
            extFetch_q <= 1'b0;
        end
        else
        begin
            altIn_q <= altIn_d;
            ale_q <= ale_d;
            psenN_q <= psenN_d;
            // (RQ14) fetch select sampled every clock out of reset
            extFetch_q <= ~externalFetchSelectN;
        end
    end

    assign altIn = altIn_q;
    assign addrLatchPulse = ale_q;
    assign programReadStrobeN = psenN_q;
    assign externalFetch = extFetch_q;
    // (RQ14) weak pull-up on fetch select
    assign externalFetchPullUp = 1'b1;

    // --------------------------------------------------------------
    // reset pin qualifier
    // --------------------------------------------------------------
    // (RQ13) count high clocks up to two machine cycles
    always_comb
    begin
        rstState_d = rstState_q;
        rstCnt_d = rstCnt_q;
        unique case (rstState_q)
            RST_IDLE:
            begin
                rstCnt_d = 5'h1;
                if (resetPin)
                    rstState_d = RST_COUNT;
            end
            RST_COUNT:
            begin
                if (!resetPin)
                    rstState_d = RST_IDLE;
                else if (rstCnt_q == `PMX_RST_LAST)
                    rstState_d = RST_ACTIVE;
                else
                    rstCnt_d = rstCnt_q + 5'h1;
            end
            RST_ACTIVE:
            begin
                if (!resetPin)
                    rstState_d = RST_IDLE;
            end
            default:
                rstState_d = RST_IDLE;
        endcase
    end

    // reset qualifier registers
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rstState_q <= RST_IDLE;
            rstCnt_q <= 5'h0;
            coreReset_q <= 1'b0;
        end
        else
        begin
            rstState_q <= rstState_d;
            rstCnt_q <= rstCnt_d;
            coreReset_q <= (rstState_d == RST_ACTIVE);
        end
    end

    assign coreResetReq = coreReset_q;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // helper: consecutive high clocks on the reset pin
    logic [5:0] highRun;
    always_ff @(posedge clk)
    begin
        if (!resetn)
            highRun <= 6'h0;
        else if (!resetPin)
            highRun <= 6'h0;
        else if (highRun != 6'h3F)
            highRun <= highRun + 6'h1;
    end

    p0_address_a: assert property (busReq.access && busReq.aleReq |=> pinOut[7:0] == $past(busReq.addr[7:0])
        && pinOe[7:0] == 8'hFF) else $error("low address missing"); // RQ1
    strong_two_a: assert property ((!portLatch[9] ##1 portLatch[9] [*3]) |-> pinOe[9] && $past(pinOe[9])
        ##1 !pinOe[9]) else $error("strong high not two clocks"); // RQ2
    clk_out_a: assert property (altOut.timerCClkEn && portLatch[8] |=> pinOut[8] == $past(altOut.timerCClk))
        else $error("clock-out not on pin"); // RQ3
    ctl_in_a: assert property (##1 altIn.timerCExtControl == $past(pinIn[9]))
        else $error("timer control input wrong"); // RQ4
    p2_address_a: assert property (busReq.access |=> pinOut[23:16] == $past(busReq.addr[15:8])
        && pinOe[23:16] == 8'hFF) else $error("high address missing"); // RQ5
    txd_pin_a: assert property (##1 pinOut[25] == $past(portLatch[25] & altOut.txd))
        else $error("transmit pin wrong"); // RQ7
    irq_pins_a: assert property (##1 altIn.extIrqAN == $past(pinIn[26]) && altIn.extIrqCN == $past(pinIn[35]))
        else $error("interrupt input wrong"); // RQ8
    timer_events_a: assert property (##1 altIn.timerBEventIn == $past(pinIn[29]))
        else $error("timer event wrong"); // RQ9
    wr_strobe_a: assert property (busReq.access && busReq.wrReq |=> !pinOut[30] && pinOe[30])
        else $error("write strobe not low"); // RQ10
    rd_strobe_a: assert property (busReq.access && busReq.rdReq |=> !pinOut[31] && pinOe[31])
        else $error("read strobe not low"); // RQ10
    irq_d_a: assert property (##1 altIn.extIrqDN == $past(pinIn[34]))
        else $error("interrupt D input wrong"); // RQ12
    reset_qual_a: assert property ($rose(coreResetReq) |-> highRun >= 6'(`PMX_RST_CLKS))
        else $error("reset before two machine cycles"); // RQ13
    reset_drop_a: assert property (!resetPin |=> !coreResetReq)
        else $error("reset held after pin low"); // RQ13
    fetch_sel_a: assert property (##1 externalFetch == !$past(externalFetchSelectN))
        else $error("fetch select not followed"); // RQ14
    ale_pulse_a: assert property (busReq.access && busReq.aleReq |=> addrLatchPulse)
        else $error("no address latch pulse"); // RQ15
    program_read_strobe_n_low_a: assert property (busReq.access && busReq.fetch |=> !programReadStrobeN)
        else $error("program read not low"); // RQ16
    latch_gate_a: assert property (!portLatch[8] |=> !pinOut[8] && pinOe[8])
        else $error("alternate output passed zero latch"); // RQ17
endmodule // pmx_port_mux
`default_nettype wire

// ---- tb/pmx_mem_model.sv ----
// external code and data memory with address latch, far side of the bus pins
`timescale 1ns/1ps
`default_nettype none
module pmx_mem_model (
    input wire logic clk, // core clock
    input wire logic ale, // address latch pulse
    input wire logic [7:0] adLow, // low address/data pins
    input wire logic psenN, // program read strobe
    input wire logic rdN, // data read strobe
    output logic [7:0] dataOut, // read data to pins
    output logic dataOe // model drives the pins
);
    logic [7:0] addr_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    // captures low address on the latch pulse
    always_ff @(posedge clk)
    begin
        if (ale)
        begin
            addr_q <= adLow;
        end
    end
    // answers either read strobe; content is address xor 5A
    assign dataOe = !psenN || !rdN;
    assign dataOut = dataOe ? (addr_q ^ 8'h5A) : ~last_q; // released: inverse of last
    // remembers the last value put on the pins
    always_ff @(posedge clk)
    begin
        if (dataOe)
        begin
            last_q <= dataOut;
        end
    end
endmodule // pmx_mem_model
`default_nettype wire

// ---- tb/tb_port_pin_function_mux.sv ----
// self-checking bench for the port pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb_port_pin_function_mux;
    import pmx_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [35:0] portLatch = 36'hF_FFFF_FFFF;
    pmx_bus_req_type busReq = '0;
    pmx_alt_out_type altOut = 3'h4; // transmit idles high
    logic resetPin = 1'b0;
    logic externalFetchSelectN = 1'b1;
    logic [35:0] extEn = 36'h0;
    logic [35:0] extVal = 36'h0;
    logic [35:0] pinIn, pinOut, pinOe, portRead;
    pmx_alt_in_type altIn;
    logic coreResetReq, externalFetchPullUp, externalFetch, addrLatchPulse, programReadStrobeN;
    logic [7:0] memData;
    logic memOe;
    int err_total = 0;
    int check_count = 0;
    int pins[9] = '{24, 26, 27, 35, 34, 28, 29, 8, 9};
    int gpio[5] = '{3, 9, 20, 27, 33};

    // clock at 100 ns period
    initial
    begin
        forever #50 clk = ~clk;
    end
    // wire level from all drivers, pull-up when nobody drives
    always_comb
    begin
        for (int i = 0; i < 36; i++)
        begin
            pinIn[i] = pinOe[i] ? pinOut[i] : (extEn[i] ? extVal[i] : 1'b1);
        end
        if (memOe && pinOe[7:0] === 8'h00)
        begin
            pinIn[7:0] = memData;
        end
    end

    pmx_port_mux i_pmx_port_mux (.clk(clk), .resetn(resetn), .portLatch(portLatch), .busReq(busReq),
        .altOut(altOut), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .portRead(portRead),
        .altIn(altIn), .resetPin(resetPin), .coreResetReq(coreResetReq),
        .externalFetchSelectN(externalFetchSelectN), .externalFetchPullUp(externalFetchPullUp),
        .externalFetch(externalFetch), .addrLatchPulse(addrLatchPulse),
        .programReadStrobeN(programReadStrobeN));
    pmx_mem_model i_pmx_mem_model (.clk(clk), .ale(addrLatchPulse), .adLow(pinIn[7:0]),
        .psenN(programReadStrobeN), .rdN(!(pinOe[31] && !pinOut[31])), .dataOut(memData), .dataOe(memOe));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && check_count > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic reset_values();
        chk(pinOut, 36'hF_FFFF_FFFF);
        chk(pinOe, 36'h0);
        chk(36'({altIn, addrLatchPulse, programReadStrobeN, externalFetch, coreResetReq}), 36'h1FF4);
    endtask
    task automatic quasi_rise(input int pin);
        portLatch[pin] = 1'b0;
        tick(1);
        chk(36'({pinOut[pin], pinOe[pin]}), 36'h1);
        portLatch[pin] = 1'b1;
        tick(1);
        chk(36'({pinOut[pin], pinOe[pin]}), 36'h3);
        tick(1);
        chk(36'({pinOut[pin], pinOe[pin]}), 36'h3);
        tick(1);
        chk(36'({pinOut[pin], pinOe[pin]}), 36'h2);
    endtask
    task automatic alt_inputs();
        for (int k = 0; k < 9; k++)
        begin
            extEn[pins[k]] = 1'b1;
            tick(1);
            chk(36'(altIn), {27'h0, ~(9'h100 >> k)});
            chk(36'(portRead[pins[k]]), 36'h0);
            extEn[pins[k]] = 1'b0;
            tick(1);
        end
    endtask
    task automatic alt_outputs();
        altOut.txd = 1'b0;
        tick(1);
        chk(36'({pinOut[25], pinOe[25]}), 36'h1);
        portLatch[25] = 1'b0;
        altOut.txd = 1'b1;
        tick(1);
        chk(36'({pinOut[25], pinOe[25]}), 36'h1);
        portLatch[25] = 1'b1;
        altOut = 3'h5;
        tick(1);
        chk(36'({pinOut[8], pinOe[8]}), 36'h1);
        altOut = 3'h7;
        tick(1);
        chk(36'({pinOut[8], pinOe[8]}), 36'h3);
        portLatch[8] = 1'b0;
        tick(1);
        chk(36'({pinOut[8], pinOe[8]}), 36'h1);
        portLatch[8] = 1'b1;
        altOut = 3'h4;
        tick(4);
    endtask
    task automatic ext_fetch();
        externalFetchSelectN = 1'b0;
        busReq = '{access: 1'b1, aleReq: 1'b1, fetch: 1'b1, addr: 16'hA53C, default: '0};
        tick(1);
        chk(36'({externalFetch, externalFetchPullUp, addrLatchPulse, programReadStrobeN}), 36'hE);
        chk(36'({pinOut[23:16], pinOut[7:0], pinOe[23:16], pinOe[7:0]}), 36'hA53CFFFF);
        busReq.aleReq = 1'b0;
        tick(1);
        chk(36'({addrLatchPulse, programReadStrobeN, pinOe[7:0]}), 36'h0);
        tick(1);
        chk(36'(portRead[7:0]), 36'h66);
        busReq = '0;
        externalFetchSelectN = 1'b1;
        tick(4);
    endtask
    task automatic ext_data();
        busReq = '{access: 1'b1, dataDrive: 1'b1, wrReq: 1'b1, dataOut: 8'h77, addr: 16'h1234, default: '0};
        tick(1);
        chk(36'({pinOut[31:30], pinOut[7:0], pinOe[7:0]}), 36'h277FF);
        busReq.wrReq = 1'b0;
        busReq.rdReq = 1'b1;
        busReq.dataDrive = 1'b0;
        tick(1);
        chk(36'({pinOut[31:30], pinOe[7:0]}), 36'h100);
        tick(1);
        chk(36'(portRead[7:0]), 36'h66);
        busReq = '0;
        tick(4);
    endtask
    task automatic rst_pin();
        resetPin = 1'b1;
        tick(23);
        chk(36'(coreResetReq), 36'h0);
        tick(2);
        chk(36'(coreResetReq), 36'h1);
        resetPin = 1'b0;
        tick(2);
        chk(36'(coreResetReq), 36'h0);
    endtask

    // main sequence
    initial
    begin
        tick(2);
        resetn = 1'b1;
        tick(1);
        reset_values();
        foreach (gpio[g])
        begin
            quasi_rise(gpio[g]);
        end
        alt_inputs();
        alt_outputs();
        ext_fetch();
        ext_data();
        rst_pin();
        report_and_stop();
    end
endmodule // tb_port_pin_function_mux
`default_nettype wire
